// [verilog/fwc_pkg.sv]
// shared constants, types and the checksum function for the flow word link
`default_nettype none
package fwc_pkg;

  // checksum generator shared by both ends
  localparam logic [7:0] FWC_CRC_POLY = 8'h31;
  localparam logic [7:0] FWC_CRC_INIT = 8'hFF;
  localparam logic [7:0] FWC_CRC_XOR_OUT = 8'h00;

  // conversion to physical values, results in hundredths of a unit
  localparam logic signed [16:0] FWC_FLOW_OFFSET = -17'sh03000;
  localparam logic [7:0] FWC_FLOW_SCALE = 8'h78;
  localparam logic signed [16:0] FWC_TEMP_OFFSET = 17'sh00000;
  localparam logic [7:0] FWC_TEMP_SCALE = 8'hC8;
  localparam logic signed [23:0] FWC_PHYS_FRAC = 24'sh000064;
  localparam int unsigned FWC_DIV_STEPS = 24;

  // flow unit word layout and the one supported code
  localparam int unsigned FWC_PREFIX_LSB = 0;
  localparam int unsigned FWC_TBASE_LSB = 4;
  localparam int unsigned FWC_UNIT_LSB = 8;
  localparam logic [3:0] FWC_PREFIX_ONE = 4'h8;
  localparam logic [3:0] FWC_TBASE_MINUTE = 4'h4;
  localparam logic [4:0] FWC_UNIT_STD_LITRE = 5'h01;
  localparam logic [15:0] FWC_UNIT_SLM = 16'h0148;
  localparam logic [12:0] FWC_UNIT_USED_MASK = 13'h1FFF;

  localparam int unsigned FWC_FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    FWC_KIND_FLOW,
    FWC_KIND_TEMP,
    FWC_KIND_UNIT
  } fwc_kind_e;

  function automatic logic [7:0] fwc_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ FWC_CRC_POLY) : (c << 1);
    end
    return c ^ FWC_CRC_XOR_OUT;
  endfunction : fwc_crc8

endpackage : fwc_pkg
`default_nettype wire

// [verilog/fwc_link_if.sv]
// byte stream link from the sensor end to the host end
`timescale 1ns/100ps
`default_nettype none
interface fwc_link_if;
  logic [7:0] byte_data;
  logic byte_valid;
  logic byte_ready;
  modport dev (output byte_data, output byte_valid, input byte_ready);
  modport host (input byte_data, input byte_valid, output byte_ready);
endinterface : fwc_link_if
`default_nettype wire

// [verilog/fwc_dev_end.sv]
// sensor end: serialises each word as msb, lsb, checksum
`timescale 1ns/100ps
`default_nettype none
module fwc_dev_end (
  input wire logic clk,
  input wire logic rstn,
  fwc_link_if.dev link,
  input wire logic [15:0] word_data,
  input wire logic word_valid,
  output logic word_ready
);
  typedef enum logic [1:0] {D_IDLE, D_MSB, D_LSB, D_CRC} fwc_dst_e;
  typedef struct packed {
    fwc_dst_e st;
    logic rdy;
    logic [15:0] word;
    logic [7:0] crc;
    logic [7:0] data;
    logic vld;
  } fwc_dev_s;

  fwc_dev_s s_q, s_d;
  logic sent;

  always_comb begin
    s_d = s_q;
    sent = s_q.vld && link.byte_ready;
    case (s_q.st)
      D_IDLE: begin
        if (word_valid && s_q.rdy) begin
          s_d.word = word_data;
          s_d.data = word_data[15:8];
          s_d.crc = fwc_pkg::fwc_crc8(fwc_pkg::FWC_CRC_INIT, word_data[15:8]);
          s_d.vld = 1'b1;
          s_d.rdy = 1'b0;
          s_d.st = D_MSB;
        end
      end
      D_MSB: begin
        if (sent) begin
          s_d.data = s_q.word[7:0];
          s_d.crc = fwc_pkg::fwc_crc8(s_q.crc, s_q.word[7:0]);
          s_d.st = D_LSB;
        end
      end
      D_LSB: begin
        if (sent) begin
          s_d.data = s_q.crc;
          s_d.st = D_CRC;
        end
      end
      D_CRC: begin
        // next word only after the checksum has gone
        if (sent) begin
          s_d.vld = 1'b0;
          s_d.rdy = 1'b1;
          s_d.st = D_IDLE;
        end
      end
      default: s_d.st = D_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{st: D_IDLE, rdy: 1'b1, word: 16'h0000, crc: 8'h00, data: 8'h00, vld: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.byte_data = s_q.data;
  assign link.byte_valid = s_q.vld;
  assign word_ready = s_q.rdy;
endmodule : fwc_dev_end
`default_nettype wire

// [verilog/fwc_host_end.sv]
// host end: checksum check, word buffer, conversion and unit decode
// Functional notes
// - each word is followed by one checksum byte
// - checksum covers only the two word bytes
// - crc8 poly 31, init FF, no reflection
// - flow word is signed sixteen bit
// - flow: subtract -12288, divide by 120
// - temperature: signed, offset 0, divide by 200
// - unit word: prefix, time base, unit fields
// - 0x0148 means standard litres per minute
`timescale 1ns/100ps
`default_nettype none
module fwc_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
    logic rdy;
  } fwc_fifo_s;

  fwc_fifo_s s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  always_comb begin
    s_d = s_q;
    push = in_valid && s_q.rdy;
    pop = (s_q.cnt != '0) && out_ready;
    if (push) begin
      s_d.wr = s_q.wr + AW'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + AW'(1);
    end
    s_d.cnt = CW'(s_q.cnt + CW'(push) - CW'(pop));
    // registered ready keeps the producer off a combinational path
    s_d.rdy = (s_d.cnt != CW'(DEPTH));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{wr: '0, rd: '0, cnt: '0, rdy: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_q.wr] <= in_data;
    end
  end

  assign in_ready = s_q.rdy;
  assign out_valid = (s_q.cnt != '0);
  assign out_data = mem[s_q.rd];
endmodule : fwc_fifo

module fwc_host_end #(
  parameter int unsigned FIFO_DEPTH = fwc_pkg::FWC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  fwc_link_if.host link,
  input wire fwc_pkg::fwc_kind_e word_kind,
  output logic crc_err,
  output logic out_valid,
  input wire logic out_ready,
  output fwc_pkg::fwc_kind_e out_kind,
  output logic [15:0] out_raw,
  output logic signed [23:0] out_phys,
  output logic [3:0] unit_prefix,
  output logic [3:0] unit_tbase,
  output logic [4:0] unit_base,
  output logic unit_bad
);
  typedef enum logic [1:0] {H_MSB, H_LSB, H_CRC, H_PUSH} fwc_rst_e;
  typedef enum logic [1:0] {C_IDLE, C_DIV, C_OUT} fwc_cst_e;
  typedef struct packed {
    fwc_rst_e rst;
    logic rdy;
    logic [15:0] word;
    logic [7:0] crc;
    fwc_pkg::fwc_kind_e kind;
    logic err;
    fwc_cst_e cst;
    logic neg;
    logic [23:0] quo;
    logic [7:0] rem;
    logic [7:0] div;
    logic [4:0] cnt;
    logic vld;
    fwc_pkg::fwc_kind_e okind;
    logic [15:0] oraw;
    logic signed [23:0] phys;
    logic [3:0] prefix;
    logic [3:0] tbase;
    logic [4:0] ubase;
    logic ubad;
  } fwc_host_s;

  fwc_host_s s_q, s_d;
  logic take, push, pop, fifo_rdy, fifo_vld;
  logic [17:0] fifo_out;
  fwc_pkg::fwc_kind_e pkind;
  logic [15:0] praw;
  logic signed [16:0] num;
  logic signed [23:0] prod;
  logic [8:0] r2;
  logic qbit;
  logic [23:0] qnext;

  // verified words wait here; a stalled consumer drops link ready
  fwc_fifo #(
    .WIDTH(18),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data({s_q.kind, s_q.word}),
    .out_valid(fifo_vld),
    .out_ready(pop),
    .out_data(fifo_out)
  );

  always_comb begin
    s_d = s_q;
    take = link.byte_valid && s_q.rdy;
    push = 1'b0;
    pop = 1'b0;
    pkind = fwc_pkg::fwc_kind_e'(fifo_out[17:16]);
    praw = fifo_out[15:0];
    num = 17'sh00000;
    prod = 24'sh000000;
    r2 = {s_q.rem, s_q.quo[23]};
    qbit = (r2 >= {1'b0, s_q.div});
    qnext = {s_q.quo[22:0], qbit};
    s_d.err = 1'b0;

    case (s_q.rst)
      H_MSB: begin
        if (take) begin
          s_d.word[15:8] = link.byte_data;
          s_d.crc = fwc_pkg::fwc_crc8(fwc_pkg::FWC_CRC_INIT, link.byte_data);
          s_d.kind = word_kind;
          s_d.rst = H_LSB;
        end
      end
      H_LSB: begin
        if (take) begin
          s_d.word[7:0] = link.byte_data;
          s_d.crc = fwc_pkg::fwc_crc8(s_q.crc, link.byte_data);
          s_d.rst = H_CRC;
        end
      end
      H_CRC: begin
        if (take) begin
          if (link.byte_data != s_q.crc) begin
            s_d.err = 1'b1;
            s_d.rst = H_MSB;
          end else begin
            s_d.rdy = 1'b0;
            s_d.rst = H_PUSH;
          end
        end
      end
      H_PUSH: begin
        if (fifo_rdy) begin
          push = 1'b1;
          s_d.rdy = 1'b1;
          s_d.rst = H_MSB;
        end
      end
      default: s_d.rst = H_MSB;
    endcase

    case (s_q.cst)
      C_IDLE: begin
        if (fifo_vld) begin
          pop = 1'b1;
          s_d.okind = pkind;
          s_d.oraw = praw;
          if (pkind == fwc_pkg::FWC_KIND_UNIT) begin
            s_d.prefix = praw[fwc_pkg::FWC_PREFIX_LSB +: 4];
            s_d.tbase = praw[fwc_pkg::FWC_TBASE_LSB +: 4];
            s_d.ubase = praw[fwc_pkg::FWC_UNIT_LSB +: 5];
            // top three bits are not part of the code
            s_d.ubad = (praw[12:0] & fwc_pkg::FWC_UNIT_USED_MASK) != fwc_pkg::FWC_UNIT_SLM[12:0];
            s_d.phys = 24'sh000000;
            s_d.vld = 1'b1;
            s_d.cst = C_OUT;
          end else begin
            if (pkind == fwc_pkg::FWC_KIND_TEMP) begin
              num = 17'(signed'(praw)) - fwc_pkg::FWC_TEMP_OFFSET;
              s_d.div = fwc_pkg::FWC_TEMP_SCALE;
            end else begin
              num = 17'(signed'(praw)) - fwc_pkg::FWC_FLOW_OFFSET;
              s_d.div = fwc_pkg::FWC_FLOW_SCALE;
            end
            prod = 24'(num) * fwc_pkg::FWC_PHYS_FRAC;
            s_d.neg = prod[23];
            s_d.quo = prod[23] ? 24'(-prod) : 24'(prod);
            s_d.rem = 8'h00;
            s_d.cnt = 5'h00;
            s_d.cst = C_DIV;
          end
        end
      end
      C_DIV: begin
        // bit serial divide: one quotient bit per clock, no divider array
        s_d.rem = qbit ? 8'(r2 - {1'b0, s_q.div}) : r2[7:0];
        s_d.quo = qnext;
        s_d.cnt = s_q.cnt + 5'h01;
        if (s_q.cnt == 5'(fwc_pkg::FWC_DIV_STEPS - 1)) begin
          s_d.phys = s_q.neg ? -signed'(qnext) : signed'(qnext);
          s_d.vld = 1'b1;
          s_d.cst = C_OUT;
        end
      end
      C_OUT: begin
        if (out_ready) begin
          s_d.vld = 1'b0;
          s_d.cst = C_IDLE;
        end
      end
      default: s_d.cst = C_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{rst: H_MSB, rdy: 1'b1, word: 16'h0000, crc: 8'h00, kind: fwc_pkg::FWC_KIND_FLOW,
               err: 1'b0, cst: C_IDLE, neg: 1'b0, quo: 24'h000000, rem: 8'h00, div: 8'h00,
               cnt: 5'h00, vld: 1'b0, okind: fwc_pkg::FWC_KIND_FLOW, oraw: 16'h0000,
               phys: 24'sh000000, prefix: 4'h0, tbase: 4'h0, ubase: 5'h00, ubad: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.byte_ready = s_q.rdy;
  assign crc_err = s_q.err;
  assign out_valid = s_q.vld;
  assign out_kind = s_q.okind;
  assign out_raw = s_q.oraw;
  assign out_phys = s_q.phys;
  assign unit_prefix = s_q.prefix;
  assign unit_tbase = s_q.tbase;
  assign unit_base = s_q.ubase;
  assign unit_bad = s_q.ubad;
endmodule : fwc_host_end
`default_nettype wire

// [verification/fwc_link_monitor.sv]
// checker on the byte link between the two ends
`timescale 1ns/100ps
`default_nettype none
module fwc_link_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] byte_data,
  input wire logic byte_valid,
  input wire logic byte_ready
);
  logic [1:0] cnt_q;
  logic [15:0] w_q;
  logic hs;
  assign hs = byte_valid && byte_ready;
  // own checksum, kept apart from the design's
  function automatic logic [7:0] ref_crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h31) : (c << 1);
    end
    return c;
  endfunction : ref_crc
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      w_q <= 16'h0000;
    end else if (hs) begin
      cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      w_q <= {w_q[7:0], byte_data};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence crc_take;
    hs && cnt_q == 2'h2;
  endsequence
  sequence data_take;
    hs && cnt_q != 2'h2;
  endsequence
  crc_value_a: assert property (crc_take |-> byte_data == ref_crc(w_q))
    else $error("checksum byte wrong");
  next_byte_a: assert property (data_take |=> byte_valid)
    else $error("byte missing after data byte");
  word_gap_a: assert property (crc_take |=> !byte_valid)
    else $error("no idle after checksum");
  hold_data_a: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
    else $error("byte changed before taken");
  push_gap_a: assert property (crc_take |=> !byte_ready)
    else $error("good word not pushed");
  valid_drop_a: assert property ($fell(byte_valid) |-> $past(hs && cnt_q == 2'h2))
    else $error("valid dropped inside word");
  ready_drop_a: assert property ($fell(byte_ready) |-> $past(hs && cnt_q == 2'h2))
    else $error("ready dropped outside push");
  crc_first_a: assert property (crc_take |-> $past(hs, 1) || $past(hs, 2))
    else $error("checksum without data bytes");
endmodule : fwc_link_monitor
`default_nettype wire

// [verification/flow_word_crc_and_decode_tb.sv]
// bench: both ends joined, a second host fed bytes by hand
`timescale 1ns/100ps
`default_nettype none
module flow_word_crc_and_decode_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic wv = 1'b0;
  logic ordy = 1'b0;
  logic wr, ce, ov, ub, ce2, ov2;
  fwc_pkg::fwc_kind_e wk = fwc_pkg::FWC_KIND_FLOW;
  fwc_pkg::fwc_kind_e ok;
  logic [15:0] raw, raw2;
  logic signed [23:0] ph;
  logic [3:0] up, ut;
  logic [4:0] ubs;
  int bad_count = 0;
  int cmp_count = 0;
  fwc_link_if lk ();
  fwc_link_if lk2 ();
  always #25 clk = ~clk;
  fwc_dev_end fwc_dev_end_i (.clk(clk), .rstn(rstn), .link(lk.dev), .word_data(wd), .word_valid(wv),
    .word_ready(wr));
  fwc_host_end fwc_host_end_i (.clk(clk), .rstn(rstn), .link(lk.host), .word_kind(wk), .crc_err(ce),
    .out_valid(ov), .out_ready(ordy), .out_kind(ok), .out_raw(raw), .out_phys(ph), .unit_prefix(up),
    .unit_tbase(ut), .unit_base(ubs), .unit_bad(ub));
  fwc_host_end fwc_host_end_i2 (.clk(clk), .rstn(rstn), .link(lk2.host), .word_kind(wk), .crc_err(ce2),
    .out_valid(ov2), .out_ready(1'b1), .out_kind(), .out_raw(raw2), .out_phys(), .unit_prefix(),
    .unit_tbase(), .unit_base(), .unit_bad());
  fwc_link_monitor fwc_link_monitor_i (.clk(clk), .rstn(rstn), .byte_data(lk.byte_data),
    .byte_valid(lk.byte_valid), .byte_ready(lk.byte_ready));
  task automatic finish_test();
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tmo();
    bad_count++;
    $display("MISMATCH wait expected done seen timeout");
    finish_test();
  endtask : tmo
  task automatic send(input fwc_pkg::fwc_kind_e k, input logic [15:0] d);
    for (int n = 0; wr !== 1'b1; n++) begin
      if (n > 300) tmo();
      @(posedge clk);
      #1;
    end
    wk = k;
    wd = d;
    wv = 1'b1;
    @(posedge clk);
    #1;
    wv = 1'b0;
  endtask : send
  task automatic get(input fwc_pkg::fwc_kind_e k, input logic [15:0] r, input int p, input logic eb);
    for (int n = 0; ov !== 1'b1; n++) begin
      if (n > 300) tmo();
      @(posedge clk);
      #1;
    end
    chk("kind", k, ok);
    chk("raw", r, raw);
    chk("phys", p, ph);
    chk("crc_err", 1'b0, ce);
    if (k == fwc_pkg::FWC_KIND_UNIT) begin
      chk("prefix", r[3:0], up);
      chk("tbase", r[7:4], ut);
      chk("unit", r[12:8], ubs);
      chk("unit_bad", eb, ub);
    end
    ordy = 1'b1;
    @(posedge clk);
    #1;
    ordy = 1'b0;
  endtask : get
  // holds until the host's ready is seen high at an edge
  task automatic put(input logic [7:0] b);
    lk2.byte_data = b;
    lk2.byte_valid = 1'b1;
    for (int n = 0; lk2.byte_ready !== 1'b1; n++) begin
      if (n > 50) tmo();
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask : put
  task automatic watch(input int ee, input int ev);
    int e = 0;
    int v = 0;
    lk2.byte_valid = 1'b0;
    lk2.byte_data = ~lk2.byte_data;
    // error pulse stands one cycle only, so look before the first edge
    repeat (10) begin
      e += (ce2 === 1'b1);
      v += (ov2 === 1'b1);
      if (ov2 === 1'b1) chk("raw2", 16'hBEEF, raw2);
      @(posedge clk);
      #1;
    end
    chk("crc_err", ee, e);
    chk("out_count", ev, v);
  endtask : watch
  task automatic t_conv();
    logic [15:0] r[9] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h00C8, 16'hFF38, 16'hFFFF, 16'h0148, 16'hE148, 16'h0149};
    int p[9] = '{10240, 37545, -17066, 100, -100, 0, 0, 0, 0};
    for (int i = 0; i < 9; i++) send(fwc_pkg::fwc_kind_e'(i / 3), r[i]);
    for (int i = 0; i < 9; i++) get(fwc_pkg::fwc_kind_e'(i / 3), r[i], p[i], i == 8);
  endtask : t_conv
  // ten words against nine places: the link must refuse, then order must hold
  task automatic t_fill();
    fork
      for (int i = 0; i < 10; i++) send(fwc_pkg::FWC_KIND_UNIT, 16'h0148 + i[15:0]);
    join_none
    repeat (60) @(posedge clk);
    #1;
    chk("link_ready", 1'b0, lk.byte_ready);
    for (int i = 0; i < 10; i++) get(fwc_pkg::FWC_KIND_UNIT, 16'h0148 + i[15:0], 0, i != 0);
  endtask : t_fill
  task automatic t_crc();
    wk = fwc_pkg::FWC_KIND_UNIT;
    put(8'hBE);
    put(8'hEF);
    put(8'h92);
    watch(0, 1);
    put(8'hBE);
    put(8'hEF);
    put(8'h93);
    watch(1, 0);
  endtask : t_crc
  initial begin
    lk2.byte_data = 8'h00;
    lk2.byte_valid = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_conv();
    t_fill();
    t_crc();
    finish_test();
  end
endmodule : flow_word_crc_and_decode_tb
`default_nettype wire
